// file: src/cimd_pkg.sv
// Constants, register map and types of the control input mode decoder
// Overview of operation
// (R1) Mode 0 makes pins 1/1n one checked pair and pins 2/2n a second pair, each one logical line.
// (R2) A pair flags an error on equal levels when inverse, or on differing levels when homogeneous.
// (R3) Mode 1 keeps pins 1/1n as a checked pair and uses pins 2 and 2n as two single lines.
// (R4) Mode 2 uses all four pins as single lines and checks no pair.
// (R5) Mode 3 reads the four pins as a preselection code: four Gray-coded points or sixteen.
// (R6) Group B has its own mode setting with the same four options as group A.
// (R7) Each decoded line takes its action and switching behaviour from its own settings.
// (R8) Each mode setting takes values 0 to 3 and resets to 0, two checked pairs.
// (R9) The outside source drives each pair in the configured relation, so no error arises.
// (R10) All eight pins pass a two-stage synchroniser before decoding or checking.
`default_nettype none
package cimd_pkg;

	// Group mode settings
	typedef enum logic [1:0] {
		CIMD_MODE_PAIRS   = 2'b00,
		CIMD_MODE_MIXED   = 2'b01,
		CIMD_MODE_SINGLES = 2'b10,
		CIMD_MODE_PRESEL  = 2'b11
	} cimd_mode_t;

	// Register byte offsets
	localparam logic [7:0] CIMD_OFF_CTRL     = 8'h00;
	localparam logic [7:0] CIMD_OFF_STATUS   = 8'h04;
	localparam logic [7:0] CIMD_OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] CIMD_OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] CIMD_OFF_PRESEL   = 8'h10;
	localparam logic [7:0] CIMD_OFF_LINE_CFG = 8'h20;

	// Control word fields
	localparam int CIMD_CTRL_MODE_A  = 0;
	localparam int CIMD_CTRL_MODE_B  = 2;
	localparam int CIMD_CTRL_HOMOG   = 4;
	localparam int CIMD_CTRL_GRAY_A  = 8;
	localparam int CIMD_CTRL_GRAY_B  = 9;
	localparam int CIMD_CTRL_W       = 10;
	localparam logic [9:0] CIMD_CTRL_RST = 10'h000;

	// Per-line setting fields
	localparam int CIMD_LCFG_ACT     = 0;
	localparam int CIMD_LCFG_ACT_W   = 5;
	localparam int CIMD_LCFG_BEH     = 8;
	localparam int CIMD_LCFG_BEH_W   = 2;
	localparam logic [4:0] CIMD_ACT_MAX = 5'h18;
	localparam logic [6:0] CIMD_LCFG_RST = 7'h00;

	// Status, preselection and interrupt fields
	localparam int CIMD_STAT_ERR     = 8;
	localparam int CIMD_STAT_EN      = 16;
	localparam int CIMD_PRESEL_B     = 4;
	localparam int CIMD_PRESEL_EN    = 8;
	localparam int CIMD_IRQ_W        = 6;
	localparam int CIMD_IRQ_PRESEL   = 4;
	localparam logic [5:0] CIMD_IRQ_RST = 6'h00;

	// Bus answers
	localparam logic [1:0] CIMD_RESP_OKAY   = 2'b00;
	localparam logic [1:0] CIMD_RESP_SLVERR = 2'b10;

	// Synchroniser depth
	localparam int CIMD_SYNC_STAGES = 2;

endpackage
`default_nettype wire

// file: src/cimd_group_dec.sv
// Combinational decoder for one group of four control pins
`timescale 1ns/100ps
`default_nettype none
module cimd_group_dec
	import cimd_pkg::*;
(
	// Synchronised pins: 0 line_1, 1 line_1n, 2 line_2, 3 line_2n
	input  wire logic [3:0] pins_i,
	// Group settings
	input  wire logic [1:0] mode_i,
	input  wire logic [1:0] homog_i,
	input  wire logic       gray_i,
	// Decoded lines
	output logic [3:0]      line_val_o,
	output logic [3:0]      line_en_o,
	output logic [1:0]      pair_err_o,
	output logic [3:0]      presel_o,
	output logic            presel_en_o
);

	// Pair check: inverse wants differing levels, homogeneous equal ones
	function automatic logic pair_bad(input logic a, input logic b, input logic homog);
		pair_bad = homog ? (a != b) : (a == b); // (R2)
	endfunction

	logic bad0;
	logic bad1;

	assign bad0 = pair_bad(pins_i[0], pins_i[1], homog_i[0]);
	assign bad1 = pair_bad(pins_i[2], pins_i[3], homog_i[1]);

	// Mode decode; a faulty pair reads as inactive for safety
	always_comb
	begin
		line_val_o  = 4'h0;
		line_en_o   = 4'h0;
		pair_err_o  = 2'b00;
		presel_o    = 4'h0;
		presel_en_o = 1'b0;
		case (cimd_mode_t'(mode_i))
			CIMD_MODE_PAIRS:
			begin
				line_en_o     = 4'h5; // (R1)
				pair_err_o    = {bad1, bad0};
				line_val_o[0] = pins_i[0] & ~bad0;
				line_val_o[2] = pins_i[2] & ~bad1;
			end
			CIMD_MODE_MIXED:
			begin
				line_en_o     = 4'hD; // (R3)
				pair_err_o    = {1'b0, bad0};
				line_val_o[0] = pins_i[0] & ~bad0;
				line_val_o[3:2] = pins_i[3:2];
			end
			CIMD_MODE_SINGLES:
			begin
				line_en_o  = 4'hF; // (R4)
				line_val_o = pins_i;
			end
			CIMD_MODE_PRESEL:
			begin
				presel_en_o = 1'b1; // (R5)
				if (gray_i)
					presel_o = {2'b00, pins_i[1], pins_i[1] ^ pins_i[0]};
				else
					presel_o = pins_i;
			end
			default:
			begin
				line_en_o = 4'h0;
			end
		endcase
	end

endmodule // cimd_group_dec
`default_nettype wire

// file: src/cimd_top.sv
// Control input mode decoder with AXI4-Lite registers and interrupt
`timescale 1ns/100ps
`default_nettype none
module cimd_top
	import cimd_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int NUM_ACT = 25
)
(
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Group A pins
	input  wire logic               grp_a_line_1_i,
	input  wire logic               grp_a_line_1n_i,
	input  wire logic               grp_a_line_2_i,
	input  wire logic               grp_a_line_2n_i,
	// Group B pins
	input  wire logic               grp_b_line_1_i,
	input  wire logic               grp_b_line_1n_i,
	input  wire logic               grp_b_line_2_i,
	input  wire logic               grp_b_line_2n_i,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire logic               s_axi_awvalid_i,
	output logic                    s_axi_awready_o,
	// AXI4-Lite write data
	input  wire logic [31:0]        s_axi_wdata_i,
	input  wire logic [3:0]         s_axi_wstrb_i,
	input  wire logic               s_axi_wvalid_i,
	output logic                    s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]              s_axi_bresp_o,
	output logic                    s_axi_bvalid_o,
	input  wire logic               s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,
	input  wire logic               s_axi_arvalid_i,
	output logic                    s_axi_arready_o,
	output logic [31:0]             s_axi_rdata_o,
	output logic [1:0]              s_axi_rresp_o,
	output logic                    s_axi_rvalid_o,
	input  wire logic               s_axi_rready_i,
	// Decoded lines and actions
	output logic [7:0]              line_o,
	output logic [7:0]              line_en_o,
	output logic [3:0]              pair_err_o,
	output logic [3:0]              presel_a_o,
	output logic [3:0]              presel_b_o,
	output logic [1:0]              presel_en_o,
	output logic [NUM_ACT-1:0]      act_req_o,
	// Interrupt
	output logic                    irq_o
);

	// Mapped-address check, shared by read and write paths
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		w = a & ~ADDR_W'(3);
		addr_ok = (w == ADDR_W'(CIMD_OFF_CTRL)) || (w == ADDR_W'(CIMD_OFF_STATUS)) ||
			(w == ADDR_W'(CIMD_OFF_IRQ_STAT)) || (w == ADDR_W'(CIMD_OFF_IRQ_MASK)) ||
			(w == ADDR_W'(CIMD_OFF_PRESEL)) ||
			((w >= ADDR_W'(CIMD_OFF_LINE_CFG)) && (w < ADDR_W'(CIMD_OFF_LINE_CFG + 8'h20)));
	endfunction

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] lane_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int k = 0; k < 4; k++)
			lane_merge[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
	endfunction

	// Action code to request vector; codes above the top one request nothing
	function automatic logic [NUM_ACT-1:0] act_vec(input logic [4:0] code);
		act_vec = '0;
		if ((code != 5'h00) && (code <= CIMD_ACT_MAX))
			act_vec[code] = 1'b1;
	endfunction

	// Two-stage synchronisers; stage one feeds only stage two
	logic [7:0] pins_raw;
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;

	assign pins_raw = {grp_b_line_2n_i, grp_b_line_2_i, grp_b_line_1n_i, grp_b_line_1_i,
		grp_a_line_2n_i, grp_a_line_2_i, grp_a_line_1n_i, grp_a_line_1_i};

	generate
		for (genvar g = 0; g < 8; g++)
		begin : g_sync
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
				end
				else
				begin
					sync1_q[g] <= pins_raw[g]; // (R10)
					sync2_q[g] <= sync1_q[g];
				end
			end
		end
	endgenerate

	// Register state
	logic [CIMD_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [CIMD_IRQ_W-1:0]  stat_q, stat_d;
	logic [CIMD_IRQ_W-1:0]  mask_q, mask_d;
	logic [6:0]             lcfg_q [8];
	logic [6:0]             lcfg_d [8];

	// Per-group decoders
	logic [7:0] dec_val;
	logic [7:0] dec_en;
	logic [3:0] dec_err;
	logic [7:0] dec_presel;
	logic [1:0] dec_presel_en;

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_grp
			cimd_group_dec u_dec (
				.pins_i      (sync2_q[g*4 +: 4]),
				.mode_i      (ctrl_q[CIMD_CTRL_MODE_A + 2*g +: 2]), // (R6)
				.homog_i     (ctrl_q[CIMD_CTRL_HOMOG + 2*g +: 2]),
				.gray_i      (ctrl_q[CIMD_CTRL_GRAY_A + g]),
				.line_val_o  (dec_val[g*4 +: 4]),
				.line_en_o   (dec_en[g*4 +: 4]),
				.pair_err_o  (dec_err[g*2 +: 2]),
				.presel_o    (dec_presel[g*4 +: 4]),
				.presel_en_o (dec_presel_en[g])
			);
		end
	endgenerate

	// Decoded state
	logic [7:0]         line_q, line_d;
	logic [7:0]         len_q, len_d;
	logic [3:0]         err_q, err_d;
	logic [7:0]         psel_q, psel_d;
	logic [1:0]         psen_q, psen_d;
	logic [NUM_ACT-1:0] act_q, act_d;
	logic [7:0]         lv_q, lv_d;
	logic [CIMD_IRQ_W-1:0] ev_set;

	// Line actions: level lines request while active, edge lines pulse on activation
	always_comb
	begin
		line_d = dec_val;
		len_d  = dec_en;
		err_d  = dec_err;
		psel_d = dec_presel;
		psen_d = dec_presel_en;
		act_d  = '0;
		for (int i = 0; i < 8; i++)
		begin
			lv_d[i] = dec_en[i] & (dec_val[i] ^ lcfg_q[i][6]);
			if (lv_d[i] && (!lcfg_q[i][5] || !lv_q[i]))
				act_d = act_d | act_vec(lcfg_q[i][4:0]); // (R7)
		end
		ev_set[3:0] = err_d & ~err_q;
		ev_set[CIMD_IRQ_PRESEL]     = psen_d[0] & psen_q[0] & (psel_d[3:0] != psel_q[3:0]);
		ev_set[CIMD_IRQ_PRESEL + 1] = psen_d[1] & psen_q[1] & (psel_d[7:4] != psel_q[7:4]);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			line_q <= 8'h00;
			len_q  <= 8'h00;
			err_q  <= 4'h0;
			psel_q <= 8'h00;
			psen_q <= 2'b00;
			act_q  <= '0;
			lv_q   <= 8'h00;
		end
		else
		begin
			line_q <= line_d;
			len_q  <= len_d;
			err_q  <= err_d; // (R2)
			psel_q <= psel_d;
			psen_q <= psen_d;
			act_q  <= act_d;
			lv_q   <= lv_d;
		end
	end

	// Bus state
	logic                awready_q, awready_d;
	logic                wready_q, wready_d;
	logic                aw_hold_q, aw_hold_d;
	logic                w_hold_q, w_hold_d;
	logic [ADDR_W-1:0]   awaddr_q, awaddr_d;
	logic [31:0]         wdata_q, wdata_d;
	logic [3:0]          wstrb_q, wstrb_d;
	logic                bvalid_q, bvalid_d;
	logic [1:0]          bresp_q, bresp_d;
	logic                arready_q, arready_d;
	logic                rvalid_q, rvalid_d;
	logic [31:0]         rdata_q, rdata_d;
	logic [1:0]          rresp_q, rresp_d;
	logic                irq_q, irq_d;

	// Bus slave and register file; writes land once both address and data are held
	always_comb
	begin
		logic [ADDR_W-1:0] wa;
		logic [ADDR_W-1:0] ra;
		logic [31:0]       cur;
		logic [31:0]       nw;
		logic [CIMD_IRQ_W-1:0] clr;
		wa  = awaddr_q & ~ADDR_W'(3);
		ra  = s_axi_araddr_i & ~ADDR_W'(3);
		cur = 32'h0000_0000;
		nw  = 32'h0000_0000;
		clr = '0;
		ctrl_d    = ctrl_q;
		mask_d    = mask_q;
		lcfg_d    = lcfg_q;
		aw_hold_d = aw_hold_q;
		w_hold_d  = w_hold_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (bvalid_q && s_axi_bready_i)
			bvalid_d = 1'b0;
		if (aw_hold_q && w_hold_q && !bvalid_q)
		begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = addr_ok(awaddr_q) ? CIMD_RESP_OKAY : CIMD_RESP_SLVERR;
			if (wa == ADDR_W'(CIMD_OFF_CTRL))
			begin
				nw = lane_merge({22'h0, ctrl_q}, wdata_q, wstrb_q);
				ctrl_d = nw[CIMD_CTRL_W-1:0]; // (R8)
			end
			else if (wa == ADDR_W'(CIMD_OFF_IRQ_STAT))
			begin
				nw  = lane_merge(32'h0000_0000, wdata_q, wstrb_q);
				clr = nw[CIMD_IRQ_W-1:0];
			end
			else if (wa == ADDR_W'(CIMD_OFF_IRQ_MASK))
			begin
				nw = lane_merge({26'h0, mask_q}, wdata_q, wstrb_q);
				mask_d = nw[CIMD_IRQ_W-1:0];
			end
			else if (addr_ok(awaddr_q) && (wa >= ADDR_W'(CIMD_OFF_LINE_CFG)))
			begin
				cur = {22'h0, lcfg_q[wa[4:2]][6:5], 3'h0, lcfg_q[wa[4:2]][4:0]};
				nw  = lane_merge(cur, wdata_q, wstrb_q);
				lcfg_d[wa[4:2]] = {nw[CIMD_LCFG_BEH +: CIMD_LCFG_BEH_W],
					nw[CIMD_LCFG_ACT +: CIMD_LCFG_ACT_W]}; // (R7)
			end
		end
		if (s_axi_awvalid_i && awready_q)
		begin
			aw_hold_d = 1'b1;
			awaddr_d  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_q)
		begin
			w_hold_d = 1'b1;
			wdata_d  = s_axi_wdata_i;
			wstrb_d  = s_axi_wstrb_i;
		end
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d  = !w_hold_d && !bvalid_d;
		// Set wins over a same-cycle clear
		stat_d = (stat_q & ~clr) | ev_set;
		if (rvalid_q && s_axi_rready_i)
			rvalid_d = 1'b0;
		if (s_axi_arvalid_i && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = addr_ok(s_axi_araddr_i) ? CIMD_RESP_OKAY : CIMD_RESP_SLVERR;
			rdata_d  = 32'h0000_0000;
			if (ra == ADDR_W'(CIMD_OFF_CTRL))
				rdata_d = {22'h0, ctrl_q};
			else if (ra == ADDR_W'(CIMD_OFF_STATUS))
				rdata_d = {8'h00, len_q, 4'h0, err_q, line_q};
			else if (ra == ADDR_W'(CIMD_OFF_IRQ_STAT))
				rdata_d = {26'h0, stat_q};
			else if (ra == ADDR_W'(CIMD_OFF_IRQ_MASK))
				rdata_d = {26'h0, mask_q};
			else if (ra == ADDR_W'(CIMD_OFF_PRESEL))
				rdata_d = {22'h0, psen_q, psel_q};
			else if (addr_ok(s_axi_araddr_i) && (ra >= ADDR_W'(CIMD_OFF_LINE_CFG)))
				rdata_d = {22'h0, lcfg_q[ra[4:2]][6:5], 3'h0, lcfg_q[ra[4:2]][4:0]};
		end
		arready_d = !rvalid_d;
		irq_d = |(stat_d & mask_d);
	end

	// Bus and register flops
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_q    <= CIMD_CTRL_RST; // (R8)
			stat_q    <= CIMD_IRQ_RST;
			mask_q    <= CIMD_IRQ_RST;
			for (int i = 0; i < 8; i++)
				lcfg_q[i] <= CIMD_LCFG_RST;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= CIMD_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= CIMD_RESP_OKAY;
			irq_q     <= 1'b0;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			lcfg_q    <= lcfg_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			irq_q     <= irq_d;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o  = wready_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;
	assign line_o          = line_q;
	assign line_en_o       = len_q;
	assign pair_err_o      = err_q;
	assign presel_a_o      = psel_q[3:0];
	assign presel_b_o      = psel_q[7:4];
	assign presel_en_o     = psen_q;
	assign act_req_o       = act_q;
	assign irq_o           = irq_q;

endmodule // cimd_top
`default_nettype wire

// file: sim/cimd_sw_model.sv
// Model of the external switches driving both pin groups
`timescale 1ns/100ps
`default_nettype none
module cimd_sw_model
(
	// Commanded wiring and levels
	input  wire logic [1:0] mode_a_i,
	input  wire logic [1:0] mode_b_i,
	input  wire logic [3:0] homog_i,
	input  wire logic [3:0] fault_i,
	input  wire logic [7:0] lvl_i,
	// Pin levels, slot order
	output logic [7:0]      pins_o
);
	logic [3:0] paired;

	// Pairs wired as two channels: first pair in modes 0 and 1, second pair in mode 0 only
	always_comb
	begin
		paired[0] = mode_a_i < 2'h2;
		paired[1] = mode_a_i == 2'h0;
		paired[2] = mode_b_i < 2'h2;
		paired[3] = mode_b_i == 2'h0;
	end

	// Second channel follows the first; a fault breaks the relation on purpose
	always_comb
	begin
		pins_o = lvl_i;
		for (int p = 0; p < 4; p++)
			if (paired[p])
				pins_o[2*p+1] = (homog_i[p] ? lvl_i[2*p] : ~lvl_i[2*p]) ^ fault_i[p];
	end
endmodule // cimd_sw_model
`default_nettype wire

// file: sim/cimd_chk_asserts.sv
// Concurrent checks on the decoder's ports
`timescale 1ns/100ps
`default_nettype none
module cimd_chk
(
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Bus handshakes
	input wire logic       s_axi_awvalid_i,
	input wire logic       s_axi_awready_o,
	input wire logic       s_axi_wvalid_i,
	input wire logic       s_axi_wready_o,
	input wire logic       s_axi_bvalid_o,
	input wire logic       s_axi_arvalid_i,
	input wire logic       s_axi_arready_o,
	input wire logic       s_axi_rvalid_o,
	// Decoded outputs
	input wire logic [7:0] line_o,
	input wire logic [7:0] line_en_o,
	input wire logic [3:0] pair_err_o,
	input wire logic [3:0] presel_a_o,
	input wire logic [3:0] presel_b_o,
	input wire logic [1:0] presel_en_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Errored pairs never report an active line
	err_zero_a: assert property (!(|(pair_err_o & {line_o[6], line_o[4], line_o[2], line_o[0]})))
		else $error("errored pair shows active line");
	// First pair of group A is checked only in modes 0 and 1
	err_a1_mode_a: assert property (pair_err_o[0] |-> line_en_o[1:0] == 2'h1)
		else $error("pair 1 error outside pair modes");
	// Second pair of group A is checked only in mode 0
	err_a2_mode_a: assert property (pair_err_o[1] |-> line_en_o[3:0] == 4'h5)
		else $error("pair 2 error outside mode 0");
	// Group A slots follow one of the four layouts
	en_a_a: assert property (line_en_o[3:0] inside {4'h5, 4'hD, 4'hF, 4'h0})
		else $error("group A layout invalid");
	// Group B has the same layouts
	en_b_a: assert property (line_en_o[7:4] inside {4'h5, 4'hD, 4'hF, 4'h0})
		else $error("group B layout invalid");
	// Preselection index is zero unless enabled
	presel_off_a: assert property ((presel_en_o[0] || presel_a_o == 4'h0) && (presel_en_o[1] || presel_b_o == 4'h0))
		else $error("preselection index while disabled");
	// Preselection mode on group A carries no lines and no pairs
	presel_lines_a: assert property (presel_en_o[0] |-> line_en_o[3:0] == 4'h0 && pair_err_o[1:0] == 2'h0)
		else $error("lines active in preselection mode");
	// Write answered two edges after both halves taken
	wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write response late");
	// Read answered on the edge after the address is taken
	rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read response late");
	// No new request accepted while an answer is pending
	bus_busy_a: assert property ((s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) and (s_axi_rvalid_o |-> !s_axi_arready_o))
		else $error("ready while response pending");

	// Main scenarios reached
	cov_err: cover property (pair_err_o == 4'hF);
	cov_presel: cover property (presel_en_o == 2'h3);
	cov_write: cover property (s_axi_bvalid_o);
endmodule // cimd_chk
bind cimd_top cimd_chk u_chk (.*);
`default_nettype wire

// file: sim/tb_cimd_top.sv
// Testbench for the control input mode decoder
`timescale 1ns/100ps
`default_nettype none
module tb_cimd_top
	import cimd_pkg::*;
;
	// Stimulus
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic [1:0]  ma = 2'h0, mb = 2'h0;
	logic [3:0]  hom = 4'h0, flt = 4'h0;
	logic [7:0]  lvl = 8'h00;
	// Observed
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, irq_o;
	logic        s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, presel_en_o;
	logic [31:0] s_axi_rdata_o;
	logic [7:0]  line_o, line_en_o;
	logic [3:0]  pair_err_o, presel_a_o, presel_b_o;
	logic [24:0] act_req_o;
	logic [31:0] d;
	logic [1:0]  r;
	logic [7:0]  en;
	logic [31:0] ex, n_pulse;
	int          failures = 0, n_compared = 0;
	// Pins from the switch model
	wire logic [7:0] pins;
	wire logic grp_a_line_1_i = pins[0];
	wire logic grp_a_line_1n_i = pins[1];
	wire logic grp_a_line_2_i = pins[2];
	wire logic grp_a_line_2n_i = pins[3];
	wire logic grp_b_line_1_i = pins[4];
	wire logic grp_b_line_1n_i = pins[5];
	wire logic grp_b_line_2_i = pins[6];
	wire logic grp_b_line_2n_i = pins[7];

	cimd_top dut (.*);
	cimd_sw_model u_sw (.mode_a_i(ma), .mode_b_i(mb), .homog_i(hom), .fault_i(flt),
		.lvl_i(lvl), .pins_o(pins));

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	task automatic give_verdict();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Handshakes judged at the falling edge, acted on at the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		logic aw_t, w_t, b_t;
		logic [1:0] rs;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		b_t = 1'b0;
		for (n = 0; n < 50 && !b_t; n++)
		begin
			@(negedge clk_i);
			aw_t = s_axi_awvalid_i && s_axi_awready_o;
			w_t = s_axi_wvalid_i && s_axi_wready_o;
			b_t = s_axi_bready_i && s_axi_bvalid_o;
			rs = s_axi_bresp_o;
			@(posedge clk_i);
			if (aw_t)
				s_axi_awvalid_i <= 1'b0;
			if (w_t)
				s_axi_wvalid_i <= 1'b0;
			if (b_t)
				s_axi_bready_i <= 1'b0;
		end
		// One idle edge, so a following call never reassigns in the same step
		@(posedge clk_i);
		if (!b_t)
		begin
			failures++;
			give_verdict();
		end
		chk("bresp", {30'h0, er}, {30'h0, rs});
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ar_t, r_t;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		r_t = 1'b0;
		for (n = 0; n < 50 && !r_t; n++)
		begin
			@(negedge clk_i);
			ar_t = s_axi_arvalid_i && s_axi_arready_o;
			r_t = s_axi_rready_i && s_axi_rvalid_o;
			v = s_axi_rdata_o;
			rs = s_axi_rresp_o;
			@(posedge clk_i);
			if (ar_t)
				s_axi_arvalid_i <= 1'b0;
			if (r_t)
				s_axi_rready_i <= 1'b0;
		end
		// One idle edge, so a following call never reassigns in the same step
		@(posedge clk_i);
		if (!r_t)
		begin
			failures++;
			give_verdict();
		end
	endtask

	// Pins pass three edges to the outputs; five leaves margin
	task automatic settle();
		repeat (5) @(posedge clk_i);
	endtask

	function automatic logic [3:0] pat(input logic [1:0] m);
		case (m)
			2'h0: pat = 4'h5;
			2'h1: pat = 4'hD;
			2'h2: pat = 4'hF;
			default: pat = 4'h0;
		endcase
	endfunction

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		axi_rd(CIMD_OFF_CTRL, d, r);
		chk("ctrl_reset", 32'h0, d);
		axi_rd(8'h80, d, r);
		chk("bad_data", 32'h0, d);
		chk("bad_resp", {30'h0, CIMD_RESP_SLVERR}, {30'h0, r});
		axi_wr(8'h80, 32'h1, CIMD_RESP_SLVERR);
		// Every mode on A with the opposite mode on B
		for (int m = 0; m < 4; m++)
		begin
			ma <= m[1:0];
			mb <= 2'h3 - m[1:0];
			lvl <= 8'hED;
			axi_wr(CIMD_OFF_CTRL, {28'h0, 2'h3 - m[1:0], m[1:0]}, CIMD_RESP_OKAY);
			settle();
			en = {pat(mb), pat(ma)};
			axi_rd(CIMD_OFF_STATUS, d, r);
			chk("line_en", {24'h0, en}, {24'h0, d[23:16]});
			chk("line", {24'h0, lvl & en}, {24'h0, d[7:0] & en});
			chk("pair_err", 32'h0, {28'h0, d[11:8]});
			chk("line_en_port", {24'h0, en}, {24'h0, line_en_o});
			ex = {22'h0, mb == 2'h3, ma == 2'h3, mb == 2'h3 ? 4'hE : 4'h0,
				ma == 2'h3 ? 4'hD : 4'h0};
			chk("presel_port", ex, {22'h0, presel_en_o, presel_b_o, presel_a_o});
			axi_rd(CIMD_OFF_PRESEL, d, r);
			chk("presel", ex, d);
		end
		// Pair faults at both levels, inverse and homogeneous
		axi_wr(CIMD_OFF_IRQ_MASK, 32'hF, CIMD_RESP_OKAY);
		for (int i = 0; i < 4; i++)
		begin
			ma <= 2'h0;
			mb <= 2'h0;
			lvl <= i[0] ? 8'hFF : 8'h00;
			hom <= {4{i[1]}};
			axi_wr(CIMD_OFF_CTRL, {24'h0, {4{i[1]}}, 4'h0}, CIMD_RESP_OKAY);
			settle();
			chk("no_err", 32'h0, {28'h0, pair_err_o});
			flt <= 4'hF;
			settle();
			chk("err", 32'hF, {28'h0, pair_err_o});
			chk("err_line", 32'h0, {24'h0, line_o & 8'h55});
			chk("irq_on", 32'h1, {31'h0, irq_o});
			axi_rd(CIMD_OFF_IRQ_STAT, d, r);
			chk("irq_stat", 32'hF, {28'h0, d[3:0]});
			flt <= 4'h0;
			settle();
			axi_wr(CIMD_OFF_IRQ_STAT, 32'hF, CIMD_RESP_OKAY);
			repeat (2) @(posedge clk_i);
			chk("irq_off", 32'h0, {31'h0, irq_o});
		end
		// Gray-coded preselection on both groups, then a change event on each
		ma <= 2'h3;
		mb <= 2'h3;
		axi_wr(CIMD_OFF_CTRL, 32'h30F, CIMD_RESP_OKAY);
		lvl <= 8'h22;
		settle();
		chk("gray", 32'h33, {24'h0, presel_b_o, presel_a_o});
		axi_wr(CIMD_OFF_IRQ_STAT, 32'h30, CIMD_RESP_OKAY);
		lvl <= 8'h33;
		settle();
		chk("gray", 32'h22, {24'h0, presel_b_o, presel_a_o});
		axi_rd(CIMD_OFF_IRQ_STAT, d, r);
		chk("presel_irq", 32'h3, {30'h0, d[5:4]});
		// Single line with its own action
		ma <= 2'h2;
		axi_wr(CIMD_OFF_CTRL, 32'h2, CIMD_RESP_OKAY);
		axi_wr(CIMD_OFF_LINE_CFG + 8'h04, 32'h5, CIMD_RESP_OKAY);
		lvl <= 8'h02;
		settle();
		chk("action", 32'h20, {7'h0, act_req_o});
		lvl <= 8'h00;
		settle();
		chk("action", 32'h0, {7'h0, act_req_o});
		// Edge line: one pulse per activation, counted over a window
		axi_wr(CIMD_OFF_LINE_CFG + 8'h04, 32'h105, CIMD_RESP_OKAY);
		lvl <= 8'h02;
		n_pulse = 32'h0;
		repeat (8)
		begin
			@(negedge clk_i);
			n_pulse = n_pulse + {31'h0, act_req_o[5]};
		end
		chk("pulses", 32'h1, n_pulse);
		@(posedge clk_i);
		// Inverted line requests while its pin is low
		axi_wr(CIMD_OFF_LINE_CFG + 8'h04, 32'h205, CIMD_RESP_OKAY);
		lvl <= 8'h00;
		settle();
		chk("inverted", 32'h20, {7'h0, act_req_o});
		give_verdict();
	end
endmodule // tb_cimd_top
`default_nettype wire
